// File: verilog/rxq_filter_pkg.sv
// Constants shared by the receive filter and flow-control register group.
package rxq_filter_pkg;

   // ==========================================================
   // Host bus geometry and field widths
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam int WM_W   = 12;
   localparam int CNT_W  = 8;
   localparam int DA_W   = 48;
   localparam int HASH_W = 6;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_HASH_WORD2   = 11'h1A4;
   localparam logic [ADDR_W-1:0] OFF_HASH_WORD3   = 11'h1A6;
   localparam logic [ADDR_W-1:0] OFF_LOW_WM       = 11'h1B0;
   localparam logic [ADDR_W-1:0] OFF_HIGH_WM      = 11'h1B2;
   localparam logic [ADDR_W-1:0] OFF_OVERRUN_WM   = 11'h1B4;
   localparam logic [ADDR_W-1:0] OFF_FRAME_COUNT  = 11'h1B8;
   localparam logic [ADDR_W-1:0] OFF_ANALOG_ONE   = 11'h748;
   localparam logic [ADDR_W-1:0] OFF_ANALOG_THREE = 11'h74C;

   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] RST_HASH       = 16'h0000;
   localparam logic [WM_W-1:0]   RST_LOW_WM     = 12'h600;
   localparam logic [WM_W-1:0]   RST_HIGH_WM    = 12'h400;
   localparam logic [WM_W-1:0]   RST_OVERRUN_WM = 12'h040;
   localparam logic [CNT_W-1:0]  RST_COUNT      = 8'h00;

   // ==========================================================
   // Field positions
   localparam int COUNT_LSB       = 8;
   localparam int REG_DISABLE_BIT = 7;
   localparam int PULSE_MASK_BIT  = 15;
   localparam int BIAS_REDUCE_BIT = 3;

   // ==========================================================
   // Hash computation
   localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

endpackage

// File: verilog/hash_if.sv
// Carrier between the filter register bank and its hash calculator.
`timescale 1ns/10ps
interface hash_if;
   logic                                 da_valid;
   logic [rxq_filter_pkg::DA_W-1:0]      da;
   logic                                 idx_valid;
   logic [rxq_filter_pkg::HASH_W-1:0]    idx;

   modport calc (
      input  da_valid,
      input  da,
      output idx_valid,
      output idx
   );
   modport user (
      output da_valid,
      output da,
      input  idx_valid,
      input  idx
   );
endinterface

// File: verilog/mcast_hash_calc.sv
// Destination-address CRC hash: six index bits, one cycle after the address.
`timescale 1ns/10ps
module mcast_hash_calc (
   // Clock and reset
   input  logic   clk_i,
   input  logic   rst_i,
   // Address in, index out
   hash_if.calc   h
);

   // ==========================================================
   // CRC over the address, first byte first, each byte LSB first
   function automatic logic [31:0] crc_of(
      input logic [rxq_filter_pkg::DA_W-1:0] da);
      logic [31:0] crc;
      logic        fb;
      int          k;
      int          j;
      crc = rxq_filter_pkg::CRC_INIT;
      for (k = 0; k < 6; k++) begin
         for (j = 0; j < 8; j++) begin
            fb  = crc[31] ^ da[40 - 8*k + j];
            crc = {crc[30:0], 1'b0} ^ (fb ? rxq_filter_pkg::CRC_POLY
                                          : 32'h00000000);
         end
      end
      return crc;
   endfunction

   wire [31:0] crc_w = crc_of(h.da);

   // ==========================================================
   // Registered index
   // top six bits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         h.idx_valid <= 1'b0;
         h.idx       <= 6'h00;
      end else begin
         h.idx_valid <= h.da_valid;
         h.idx       <= crc_w[31:26];
      end
   end

   a_hash_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      h.da_valid |=> h.idx_valid && h.idx == $past(crc_w[31:26]))
      else $error("hash index not produced one cycle after address");

endmodule

// File: verilog/rx_queue_filter_flow_regs.sv
// Receive multicast hash filter, flow-control watermarks and analog bits.
//
// How it works
// - Frame whose hash table bit is one is accepted unfiltered.
// - Frame whose hash table bit is zero is discarded unless receive-all and multicast filtering are both set.
// - Index is top six CRC bits of address; two pick word, four pick bit.
// - Receive-all plus multicast filtering accepts every multicast frame.
// - Twelve-bit low watermark in double words, resets to 0x600.
// - Twelve-bit high watermark in double words, resets to 0x400.
// - Twelve-bit overrun watermark in double words, resets to 0x040.
// - Upper byte shows queued frames, captured when host clears interrupt.
// - Regulator stays on while disable bit is zero; one turns it off.
`timescale 1ns/10ps
module rx_queue_filter_flow_regs (
   // Clock and reset
   input  logic                                clk_i,
   input  logic                                rst_i,
   // Host register port, synchronous to clk_i
   input  logic [rxq_filter_pkg::ADDR_W-1:0]   host_addr_i,
   input  logic                                host_wr_i,
   input  logic                                host_rd_i,
   input  logic [1:0]                          host_be_i,
   input  logic [rxq_filter_pkg::DATA_W-1:0]   host_wdata_i,
   output logic [rxq_filter_pkg::DATA_W-1:0]   host_rdata_o,
   // Lower hash words and receive control bits
   input  logic [rxq_filter_pkg::DATA_W-1:0]   hash_word0_i,
   input  logic [rxq_filter_pkg::DATA_W-1:0]   hash_word1_i,
   input  logic                                recv_all_i,
   input  logic                                mcast_addr_filter_i,
   // Multicast frame to be judged
   input  logic                                mcast_valid_i,
   input  logic [rxq_filter_pkg::DA_W-1:0]     mcast_da_i,
   output logic                                accept_o,
   output logic                                discard_o,
   // Receive queue status
   input  logic [rxq_filter_pkg::CNT_W-1:0]    queue_frames_i,
   input  logic                                rx_int_clear_i,
   // Flow-control watermarks
   output logic [rxq_filter_pkg::WM_W-1:0]     low_watermark_o,
   output logic [rxq_filter_pkg::WM_W-1:0]     high_watermark_o,
   output logic [rxq_filter_pkg::WM_W-1:0]     overrun_watermark_o,
   // Analog controls
   output logic                                regulator_disable_o,
   output logic                                diag_pulse_mask_o,
   output logic                                diag_rx_bias_reduce_o
);

   // ==========================================================
   // Address decode
   wire hit_hash2   = host_addr_i == rxq_filter_pkg::OFF_HASH_WORD2;
   wire hit_hash3   = host_addr_i == rxq_filter_pkg::OFF_HASH_WORD3;
   wire hit_low     = host_addr_i == rxq_filter_pkg::OFF_LOW_WM;
   wire hit_high    = host_addr_i == rxq_filter_pkg::OFF_HIGH_WM;
   wire hit_overrun = host_addr_i == rxq_filter_pkg::OFF_OVERRUN_WM;
   wire hit_count   = host_addr_i == rxq_filter_pkg::OFF_FRAME_COUNT;
   wire hit_ana1    = host_addr_i == rxq_filter_pkg::OFF_ANALOG_ONE;
   wire hit_ana3    = host_addr_i == rxq_filter_pkg::OFF_ANALOG_THREE;
   wire hit_any     = hit_hash2 | hit_hash3 | hit_low | hit_high
                    | hit_overrun | hit_count | hit_ana1 | hit_ana3;

   // ==========================================================
   // Storage
   logic [15:0] hash2_q;
   logic [15:0] hash3_q;
   logic [11:0] low_q;
   logic [11:0] high_q;
   logic [11:0] overrun_q;
   logic [7:0]  count_q;
   logic        reg_off_q;
   logic        pulse_mask_q;
   logic        bias_reduce_q;
   logic [15:0] rdata_q;

   // Byte-lane merge; a lane not enabled keeps its old value.
   wire [15:0] lane_mask = {{8{host_be_i[1]}}, {8{host_be_i[0]}}};
   wire [15:0] hash2_d   = (hash2_q & ~lane_mask)
                         | (host_wdata_i & lane_mask);
   wire [15:0] hash3_d   = (hash3_q & ~lane_mask)
                         | (host_wdata_i & lane_mask);
   wire [15:0] low_d     = ({4'h0, low_q} & ~lane_mask)
                         | (host_wdata_i & lane_mask);
   wire [15:0] high_d    = ({4'h0, high_q} & ~lane_mask)
                         | (host_wdata_i & lane_mask);
   wire [15:0] overrun_d = ({4'h0, overrun_q} & ~lane_mask)
                         | (host_wdata_i & lane_mask);

   wire wr_hash2   = host_wr_i & hit_hash2;
   wire wr_hash3   = host_wr_i & hit_hash3;
   wire wr_low     = host_wr_i & hit_low;
   wire wr_high    = host_wr_i & hit_high;
   wire wr_overrun = host_wr_i & hit_overrun;
   wire wr_ana1_lo = host_wr_i & hit_ana1 & host_be_i[0];
   wire wr_ana3_lo = host_wr_i & hit_ana3 & host_be_i[0];
   wire wr_ana3_hi = host_wr_i & hit_ana3 & host_be_i[1];

   // ==========================================================
   // Hash table words
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hash2_q <= rxq_filter_pkg::RST_HASH;
         hash3_q <= rxq_filter_pkg::RST_HASH;
      end else begin
         if (wr_hash2) begin
            hash2_q <= hash2_d;
         end
         if (wr_hash3) begin
            hash3_q <= hash3_d;
         end
      end
   end

   // ==========================================================
   // Watermarks; the upper nibble is reserved and never stored.
   // watermark storage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_q     <= rxq_filter_pkg::RST_LOW_WM;
         high_q    <= rxq_filter_pkg::RST_HIGH_WM;
         overrun_q <= rxq_filter_pkg::RST_OVERRUN_WM;
      end else begin
         if (wr_low) begin
            low_q <= low_d[11:0];
         end
         if (wr_high) begin
            high_q <= high_d[11:0];
         end
         if (wr_overrun) begin
            overrun_q <= overrun_d[11:0];
         end
      end
   end

   // ==========================================================
   // Frame count
   // capture on interrupt clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= rxq_filter_pkg::RST_COUNT;
      end else if (rx_int_clear_i) begin
         count_q <= queue_frames_i;
      end
   end

   // ==========================================================
   // Analog controls
   // regulator off bit and the two diagnostic bits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_off_q     <= 1'b0;
         pulse_mask_q  <= 1'b0;
         bias_reduce_q <= 1'b0;
      end else begin
         if (wr_ana1_lo) begin
            reg_off_q <= host_wdata_i[rxq_filter_pkg::REG_DISABLE_BIT];
         end
         if (wr_ana3_hi) begin
            pulse_mask_q <= host_wdata_i[rxq_filter_pkg::PULSE_MASK_BIT];
         end
         if (wr_ana3_lo) begin
            bias_reduce_q <= host_wdata_i[rxq_filter_pkg::BIAS_REDUCE_BIT];
         end
      end
   end

   // ==========================================================
   // Read path
   // reserved space reads zero
   wire [15:0] rd_mux =
        hit_hash2   ? hash2_q
      : hit_hash3   ? hash3_q
      : hit_low     ? {4'h0, low_q}
      : hit_high    ? {4'h0, high_q}
      : hit_overrun ? {4'h0, overrun_q}
      : hit_count   ? {count_q, 8'h00}
      : hit_ana1    ? {8'h00, reg_off_q, 7'h00}
      : hit_ana3    ? {pulse_mask_q, 11'h000, bias_reduce_q, 3'h0}
      :               16'h0000;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 16'h0000;
      end else if (host_rd_i) begin
         rdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // Multicast filter
   hash_if hif ();

   assign hif.da_valid = mcast_valid_i;
   assign hif.da       = mcast_da_i;

   mcast_hash_calc u_hash (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .h     (hif.calc)
   );

   wire [63:0] table_w  = {hash3_q, hash2_q, hash_word1_i, hash_word0_i};
   wire        hash_bit = table_w[hif.idx];
   wire        pass_all = recv_all_i & mcast_addr_filter_i;

   logic accept_q;
   logic discard_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         accept_q  <= 1'b0;
         discard_q <= 1'b0;
      end else begin
         accept_q  <= hif.idx_valid & (pass_all | hash_bit);
         discard_q <= hif.idx_valid & ~pass_all & ~hash_bit;
      end
   end

   // ==========================================================
   // Outputs
   assign host_rdata_o          = rdata_q;
   assign accept_o              = accept_q;
   assign discard_o             = discard_q;
   assign low_watermark_o       = low_q;
   assign high_watermark_o      = high_q;
   assign overrun_watermark_o   = overrun_q;
   assign regulator_disable_o   = reg_off_q;
   assign diag_pulse_mask_o     = pulse_mask_q;
   assign diag_rx_bias_reduce_o = bias_reduce_q;

   // ==========================================================
   // Checks
   a_accept_on_hash: assert property (
      @(posedge clk_i) disable iff (rst_i)
      hif.idx_valid && hash_bit |=> accept_o && !discard_o)
      else $error("set hash bit did not accept the frame");

   a_discard_on_hash: assert property (
      @(posedge clk_i) disable iff (rst_i)
      hif.idx_valid && !hash_bit && !pass_all |=> discard_o && !accept_o)
      else $error("clear hash bit did not discard the frame");

   a_decision_latency: assert property (
      @(posedge clk_i) disable iff (rst_i)
      mcast_valid_i |-> ##2 (accept_o ^ discard_o))
      else $error("no single decision two cycles after frame");

   a_pass_all_mode: assert property (
      @(posedge clk_i) disable iff (rst_i)
      hif.idx_valid && recv_all_i && mcast_addr_filter_i |=> accept_o)
      else $error("receive-all mode dropped a multicast frame");

   a_low_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_wr_i && hit_low && host_be_i == 2'b11
      |=> low_watermark_o == $past(host_wdata_i[11:0]))
      else $error("low watermark write lost");

   a_high_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_wr_i && hit_high && host_be_i == 2'b11
      |=> high_watermark_o == $past(host_wdata_i[11:0]))
      else $error("high watermark write lost");

   a_overrun_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_wr_i && hit_overrun && host_be_i == 2'b11
      |=> overrun_watermark_o == $past(host_wdata_i[11:0]))
      else $error("overrun watermark write lost");

   a_count_capture: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_int_clear_i ##1 (host_rd_i && hit_count && !rx_int_clear_i)
      |=> host_rdata_o == {$past(queue_frames_i, 2), 8'h00})
      else $error("frame count not captured at interrupt clear");

   a_regulator_ctl: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_ana1_lo |=> regulator_disable_o == $past(host_wdata_i[7]))
      else $error("regulator disable bit not applied");

   a_reserved_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_rd_i && !hit_any |=> host_rdata_o == 16'h0000)
      else $error("reserved address read not zero");

   a_reserved_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_wr_i && !hit_any
      |=> $stable({hash2_q, hash3_q, low_q, high_q, overrun_q, reg_off_q}))
      else $error("write to reserved address changed a register");

   a_count_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rx_int_clear_i |=> count_q == $past(count_q))
      else $error("frame count changed without interrupt clear");

   a_count_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_rd_i && hit_count |=> host_rdata_o == {$past(count_q), 8'h00})
      else $error("frame count read returned wrong value");

endmodule

// File: test/host_bus_model.sv
// Host processor model that reaches the register group over its bus.
`timescale 1ns/10ps
module host_bus_model (
   // Clock
   input  wire logic        clk_i,
   // Register port
   output logic [10:0]      addr_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic [1:0]       be_o,
   output logic [15:0]      wdata_o,
   input  wire logic [15:0] rdata_i
);
   initial begin
      addr_o  = 11'h000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      be_o    = 2'h0;
      wdata_o = 16'h0000;
   end

   // ==========================================================
   // Bus cycles
   // An idle bus shows inverted lines, so a stale value never passes.
   task automatic idle();
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      addr_o  = ~addr_o;
      wdata_o = ~wdata_o;
   endtask

   task automatic write_reg(input logic [10:0] a, input logic [1:0] b,
                            input logic [15:0] d);
      @(negedge clk_i);
      addr_o  = a;
      be_o    = b;
      wdata_o = d;
      wr_o    = 1'b1;
      @(negedge clk_i);
      idle();
   endtask

   // count read first: data is returned only after the strobe is
   // taken, so any later header read follows the count read.
   task automatic read_reg(input logic [10:0] a, output logic [15:0] d);
      @(negedge clk_i);
      addr_o = a;
      be_o   = 2'h3;
      rd_o   = 1'b1;
      @(negedge clk_i);
      idle();
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule

// File: test/rx_queue_filter_flow_regs_bench.sv
// Self-checking bench for the receive filter and flow-control registers.
`timescale 1ns/10ps
module rx_queue_filter_flow_regs_bench;
   // ==========================================================
   // Signals
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [10:0] addr;
   logic        wr, rd, acc, dis, regoff, pmask, bias;
   logic [1:0]  be;
   logic [15:0] wdata, rdata;
   logic [15:0] w0 = 16'hA5C3;
   logic [15:0] w1 = 16'h0F0F;
   logic        rall = 1'b0;
   logic        mfilt = 1'b0;
   logic        mv = 1'b0;
   logic [47:0] da = 48'h0;
   logic [7:0]  qf = 8'h00;
   logic        iclr = 1'b0;
   logic [11:0] lwm, hwm, owm;
   int          fail_count = 0;
   int          checked = 0;

   always #2 clk_i = ~clk_i;

   host_bus_model i_host_bus_model (.clk_i(clk_i), .addr_o(addr),
      .wr_o(wr), .rd_o(rd), .be_o(be), .wdata_o(wdata), .rdata_i(rdata));

   rx_queue_filter_flow_regs i_rx_queue_filter_flow_regs (
      .clk_i(clk_i), .rst_i(rst_i), .host_addr_i(addr), .host_wr_i(wr),
      .host_rd_i(rd), .host_be_i(be), .host_wdata_i(wdata),
      .host_rdata_o(rdata), .hash_word0_i(w0), .hash_word1_i(w1),
      .recv_all_i(rall), .mcast_addr_filter_i(mfilt),
      .mcast_valid_i(mv), .mcast_da_i(da), .accept_o(acc),
      .discard_o(dis), .queue_frames_i(qf), .rx_int_clear_i(iclr),
      .low_watermark_o(lwm), .high_watermark_o(hwm),
      .overrun_watermark_o(owm), .regulator_disable_o(regoff),
      .diag_pulse_mask_o(pmask), .diag_rx_bias_reduce_o(bias));

   // ==========================================================
   // Helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [10:0] a, input logic [15:0] e);
      logic [15:0] d;
      i_host_bus_model.read_reg(a, d);
      check(d, e);
   endtask

   task automatic summarize();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   function automatic logic [5:0] hash_index(input logic [47:0] a);
      logic [31:0] c;
      logic        fb;
      c = rxq_filter_pkg::CRC_INIT;
      for (int i = 0; i < 48; i++) begin
         fb = c[31] ^ a[40 - 8 * (i / 8) + i % 8];
         c  = {c[30:0], 1'b0} ^ (fb ? rxq_filter_pkg::CRC_POLY : 32'h0);
      end
      return c[31:26];
   endfunction

   // ==========================================================
   // Scenarios
   task automatic reset_values();
      logic [10:0] a[8] = '{11'h1A4, 11'h1A6, 11'h1B0, 11'h1B2, 11'h1B4,
                            11'h1B8, 11'h748, 11'h74C};
      logic [15:0] e[8] = '{16'h0, 16'h0, 16'h0600, 16'h0400, 16'h0040,
                            16'h0, 16'h0, 16'h0};
      for (int i = 0; i < 8; i++)
         rd_chk(a[i], e[i]);
      check({pmask, bias, regoff, 1'b0, lwm}, 16'h0600);
      check({4'h0, hwm}, 16'h0400);
      check({4'h0, owm}, 16'h0040);
   endtask

   task automatic watermarks();
      logic [10:0] a;
      logic [11:0] o;
      for (int i = 0; i < 3; i++) begin
         a = 11'h1B0 + 11'(2 * i);
         i_host_bus_model.write_reg(a, 2'h3, 16'hFABC);
         rd_chk(a, 16'h0ABC);
         i_host_bus_model.write_reg(a, 2'h2, 16'h0511);
         rd_chk(a, 16'h05BC);
         o = (i == 0) ? lwm : (i == 1) ? hwm : owm;
         check({4'h0, o}, 16'h05BC);
      end
   endtask

   task automatic unmapped();
      i_host_bus_model.write_reg(11'h1A8, 2'h3, 16'hFFFF);
      rd_chk(11'h1A8, 16'h0000);
      rd_chk(11'h1BA, 16'h0000);
      i_host_bus_model.write_reg(11'h74A, 2'h3, 16'hFFFF);
      rd_chk(11'h74A, 16'h0000);
      rd_chk(11'h7FE, 16'h0000);
   endtask

   // Frames go back to back; each verdict shows two falling edges on.
   task automatic frames(input logic r, input logic m);
      logic [63:0] tab;
      logic        exp[$];
      logic [47:0] f;
      tab = {16'hC0DE, 16'h3C96, w1, w0};
      for (int i = 0; i < 18; i++) begin
         @(negedge clk_i);
         rall  = r;
         mfilt = m;
         if (i >= 2) begin
            check(16'(acc), 16'(exp[0]));
            check(16'(dis), 16'(!exp.pop_front()));
         end
         f  = {24'h01005E, 8'(i * 29), 8'(i * 83 + 7), 8'(i * 5)};
         mv = (i < 16);
         da = f;
         exp.push_back((r & m) | tab[hash_index(f)]);
      end
   endtask

   task automatic hash_filter();
      i_host_bus_model.write_reg(11'h1A4, 2'h3, 16'h3C96);
      i_host_bus_model.write_reg(11'h1A6, 2'h3, 16'hC0DE);
      rd_chk(11'h1A6, 16'hC0DE);
      for (int k = 0; k < 4; k++)
         frames(k[1], k[0]);
   endtask

   task automatic frame_count();
      @(negedge clk_i);
      qf   = 8'h05;
      iclr = 1'b1;
      // The read strobe follows the clear at once, so the capture is
      // read back in the very next cycle.
      fork
         rd_chk(11'h1B8, 16'h0500);
         begin
            @(negedge clk_i);
            iclr = 1'b0;
            qf   = 8'h09;
         end
      join
      i_host_bus_model.write_reg(11'h1B8, 2'h3, 16'hFFFF);
      rd_chk(11'h1B8, 16'h0500);
      @(negedge clk_i);
      iclr = 1'b1;
      @(negedge clk_i);
      iclr = 1'b0;
      rd_chk(11'h1B8, 16'h0900);
   endtask

   task automatic analog();
      i_host_bus_model.write_reg(11'h748, 2'h3, 16'hFFFF);
      rd_chk(11'h748, 16'h0080);
      check(16'(regoff), 16'h0001);
      i_host_bus_model.write_reg(11'h748, 2'h3, 16'h0000);
      check(16'(regoff), 16'h0000);
      // Both diagnostic bits are set before any cable test would start.
      i_host_bus_model.write_reg(11'h74C, 2'h3, 16'hFFFF);
      rd_chk(11'h74C, 16'h8008);
      check(16'({pmask, bias}), 16'h0003);
      i_host_bus_model.write_reg(11'h74C, 2'h1, 16'h0000);
      rd_chk(11'h74C, 16'h8000);
      check(16'({pmask, bias}), 16'h0002);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      reset_values();
      watermarks();
      unmapped();
      hash_filter();
      frame_count();
      analog();
      summarize();
   end

   initial begin
      #40000;
      fail_count++;
      summarize();
   end
endmodule
